// file: hdl/pefim_consts.vh
// Purpose: Constants for the channel event flag and interrupt mask block
// Assumes: Registers sit in the low byte of one aligned 32-bit Wishbone word
// Notes:   Byte address of a register is four times its index
`ifndef PEFIM_CONSTS_VH
`define PEFIM_CONSTS_VH

// Register indices
`define PEFIM_IDX_SUMMARY 6'h00
`define PEFIM_IDX_MASK 6'h01
`define PEFIM_IDX_PWR 6'h02
`define PEFIM_IDX_PWR_CLR 6'h03
`define PEFIM_IDX_DISC 6'h04
`define PEFIM_IDX_DISC_CLR 6'h05
`define PEFIM_IDX_GEN_MASK 6'h10
`define PEFIM_IDX_RESET 6'h1A

// Summary and mask bit positions
`define PEFIM_BIT_SUPPLY 7
`define PEFIM_BIT_START 6
`define PEFIM_BIT_OVERCUR 5
`define PEFIM_BIT_CLASS 4
`define PEFIM_BIT_DETECT 3
`define PEFIM_BIT_DISCON 2
`define PEFIM_BIT_PGOOD 1
`define PEFIM_BIT_PENABLE 0

// General mask bit positions
`define PEFIM_GEN_IRQ_ALLOW 7
`define PEFIM_GEN_DET_CHG 1
`define PEFIM_GEN_CLS_CHG 0

// Reset register: writing one here clears every event flag
`define PEFIM_RST_FLAGS_BIT 7

// Strap counter value at which the strap is sampled, on the third edge after reset release
`define PEFIM_STRAP_WAIT 2'h2

// Reset values
`define PEFIM_MASK_RESET 8'h80
`define PEFIM_MASK_AUTO 8'hE4
`define PEFIM_GEN_RESET 8'h80
`define PEFIM_STICKY_RESET 8'h80

`endif

// file: hdl/pefim_event_irq.v
// Purpose: Per-channel power and discovery event flags, interrupt summary,
//          interrupt mask and active-low interrupt output behind Wishbone
// Assumes: Event inputs are one-cycle pulses from logic on clk_i; the
//          autonomous strap pins are asynchronous and are synchronised
// Notes:   Event flags clear on read at their clear-on-read index.
//          Register map, word index and byte address:
//            00h (00h) summary; bits 7, 6, 5, 2 are write-one-to-clear
//            01h (04h) interrupt mask, read and write
//            02h (08h) power change flags, plain read
//            03h (0Ch) power change flags, clear on read
//            04h (10h) discovery flags, plain read
//            05h (14h) discovery flags, clear on read
//            10h (40h) general mask: global allow, change-only selects
//            1Ah (68h) flag reset; a one in bit 7 clears every flag
//          Unmapped or misaligned reads return zero; writes are ignored.
//          Every access is acked one cycle after it is taken.
//          Summary bits 4, 3, 1, 0 are the OR of channel flags and only
//          clear through their flag registers, the flag reset or, for bits 4 and 3, a channel turn-off.
//          The strap is sampled three edges after reset, so mask writes
//          in that window are lost.
//
// Functional notes
// - Mask bit one lets category drive interrupt
// - Mask bit order fixed; supply bit resets one
// - Autonomous strap at power-up loads mask E4
// - Power flags: two indices, second clears on read
// - Clear-on-read releases interrupt held by register
// - Active-high per-channel flags feed summary bits
// - Power flags: pgood change high, enable low
// - Four-pair enable change flags update per channel
// - Single signature pgood flags set after both
// - Dual signature flags set per channel independently
// - Discovery flags: two indices, second clears on read
// - Channel turn-off clears its discovery flags
// - Class flags: any cycle or change only
// - Detect flags: any cycle or change only
// - Summary follows events regardless of mask
// - Interrupt needs summary, mask and global allow
// - Channel summary bits 4, 3, 1, 0 are OR of channel flags
`timescale 1ns/10ps
`include "pefim_consts.vh"
`default_nettype none

module pefim_event_irq #(
    parameter CHANNELS = 4
) (
    input wire clk_i,
    input wire rst_i,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Channel events from the port state machines
    input wire [CHANNELS-1:0] penable_change_i,
    input wire [CHANNELS-1:0] pgood_change_i,
    input wire [CHANNELS-1:0] class_done_i,
    input wire [CHANNELS-1:0] class_changed_i,
    input wire [CHANNELS-1:0] detect_done_i,
    input wire [CHANNELS-1:0] detect_changed_i,
    input wire [CHANNELS-1:0] channel_off_i,
    // Port wiring, one bit per channel pair
    input wire [CHANNELS/2-1:0] four_pair_i,
    input wire [CHANNELS/2-1:0] single_signature_i,
    // Category events kept outside this block
    input wire supply_fault_i,
    input wire start_fault_i,
    input wire overcurrent_i,
    input wire disconnect_i,
    // Autonomous strap pins
    input wire auto_mode_i,
    input wire auto_resistor_valid_i,
    output wire irq_n_o
);

    // Decodes a word index hit from the byte address alone, with no bus cycle terms
    // Misaligned byte addresses never hit, so they read back zero
    function hit;
        input [7:0] adr;
        input [5:0] idx;
        begin
            hit = (adr[7:2] == idx) && (adr[1:0] == 2'b00);
        end
    endfunction

    reg ack_reg;
    reg [7:0] rdata_reg;
    reg [7:0] mask_reg;
    reg [7:0] gen_reg;
    reg [7:0] sticky_reg;
    reg [7:0] sticky_next;
    reg [CHANNELS-1:0] pe_flag_reg;
    reg [CHANNELS-1:0] pg_flag_reg;
    reg [CHANNELS-1:0] cls_flag_reg;
    reg [CHANNELS-1:0] det_flag_reg;
    reg [CHANNELS-1:0] pg_pend_reg;
    reg irq_n_reg;
    reg [1:0] auto_mode_sync_reg;
    reg [1:0] auto_valid_sync_reg;
    reg strap_pending_reg;
    reg [1:0] strap_wait_reg;
    reg [7:0] rdata_next;
    wire access;
    wire rd_pwr_clr;
    wire rd_disc_clr;
    wire wr_lane;
    wire wr_reset_flags;
    wire [CHANNELS-1:0] pe_set;
    wire [CHANNELS-1:0] pg_set;
    wire [CHANNELS-1:0] pg_fire;
    wire [CHANNELS-1:0] cls_set;
    wire [CHANNELS-1:0] det_set;
    wire [7:0] summary;
    wire [7:0] power_flags;
    wire [7:0] discovery_flags;
    wire wr_summary;
    wire wr_mask;
    wire wr_gen;
    wire pwr_clear;
    wire disc_clear;
    wire irq_want;

    // Request is taken once, answered on the next edge
    // Ack blocks a second take while the master still holds the request
    assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_lane = access & wb_we_i & wb_sel_i[0];
    assign rd_pwr_clr = access & ~wb_we_i & hit(wb_adr_i, `PEFIM_IDX_PWR_CLR);
    assign rd_disc_clr = access & ~wb_we_i & hit(wb_adr_i, `PEFIM_IDX_DISC_CLR);
    assign wr_reset_flags = wr_lane & hit(wb_adr_i, `PEFIM_IDX_RESET)
        & wb_dat_i[`PEFIM_RST_FLAGS_BIT];

    // Write strobes per register, only the low byte lane carries data
    assign wr_summary = wr_lane & hit(wb_adr_i, `PEFIM_IDX_SUMMARY);
    assign wr_mask = wr_lane & hit(wb_adr_i, `PEFIM_IDX_MASK);
    assign wr_gen = wr_lane & hit(wb_adr_i, `PEFIM_IDX_GEN_MASK);

    // Clear terms shared by every channel of a flag register
    assign pwr_clear = rd_pwr_clr | wr_reset_flags;
    assign disc_clear = rd_disc_clr | wr_reset_flags;

    // Flag images, power-good high nibble and enable low nibble
    assign power_flags = {pg_flag_reg, pe_flag_reg};
    assign discovery_flags = {cls_flag_reg, det_flag_reg};

    // Summary ORs the channel flags, never gated by the mask
    assign summary[`PEFIM_BIT_PENABLE] = |pe_flag_reg;
    assign summary[`PEFIM_BIT_PGOOD] = |pg_flag_reg;
    assign summary[`PEFIM_BIT_DETECT] = |det_flag_reg;
    assign summary[`PEFIM_BIT_CLASS] = |cls_flag_reg;
    // Fault categories come from their own sticky bits
    assign summary[`PEFIM_BIT_SUPPLY] = sticky_reg[`PEFIM_BIT_SUPPLY];
    assign summary[`PEFIM_BIT_START] = sticky_reg[`PEFIM_BIT_START];
    assign summary[`PEFIM_BIT_OVERCUR] = sticky_reg[`PEFIM_BIT_OVERCUR];
    assign summary[`PEFIM_BIT_DISCON] = sticky_reg[`PEFIM_BIT_DISCON];

    // Pin wants to assert when an allowed, unmasked summary bit is set
    assign irq_want = gen_reg[`PEFIM_GEN_IRQ_ALLOW] & (|(summary & mask_reg));

    // Per-channel set terms; partner is the other channel of the pair
    // Pairs are fixed as channels 1+2 and 3+4, so the partner index is g ^ 1
    // and CHANNELS must stay even
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
            wire joined;
            wire single;
            assign joined = four_pair_i[g/2];
            assign single = joined & single_signature_i[g/2];
            // Enable change always lands per channel
            assign pe_set[g] = penable_change_i[g];
            // Both halves must have changed before a joint report
            assign pg_fire[g] = (pg_pend_reg[g] | pgood_change_i[g])
                & (pg_pend_reg[g ^ 1] | pgood_change_i[g ^ 1]);
            assign pg_set[g] = single ? pg_fire[g] : pgood_change_i[g];
            assign cls_set[g] = gen_reg[`PEFIM_GEN_CLS_CHG] ?
                class_changed_i[g] : class_done_i[g];
            assign det_set[g] = gen_reg[`PEFIM_GEN_DET_CHG] ?
                detect_changed_i[g] : detect_done_i[g];

            // Pending power-good half of a single-signature pair
            // A turn-off forgets a lone half so it cannot pair with a later change
            always @(posedge clk_i) begin
                if (rst_i) begin
                    pg_pend_reg[g] <= 1'b0;
                end else if (!single || pg_fire[g] || channel_off_i[g]) begin
                    pg_pend_reg[g] <= 1'b0;
                end else if (pgood_change_i[g]) begin
                    pg_pend_reg[g] <= 1'b1;
                end
            end

            // Power flags: a set in the clearing cycle is kept
            always @(posedge clk_i) begin
                if (rst_i) begin
                    pe_flag_reg[g] <= 1'b0;
                    pg_flag_reg[g] <= 1'b0;
                end else begin
                    pe_flag_reg[g] <= (pe_flag_reg[g] & ~pwr_clear)
                        | pe_set[g];
                    pg_flag_reg[g] <= (pg_flag_reg[g] & ~pwr_clear)
                        | pg_set[g];
                end
            end

            // Discovery flags also drop when the channel turns off
            always @(posedge clk_i) begin
                if (rst_i) begin
                    cls_flag_reg[g] <= 1'b0;
                    det_flag_reg[g] <= 1'b0;
                end else begin
                    cls_flag_reg[g] <= (cls_flag_reg[g]
                        & ~(disc_clear | channel_off_i[g]))
                        | cls_set[g];
                    det_flag_reg[g] <= (det_flag_reg[g]
                        & ~(disc_clear | channel_off_i[g]))
                        | det_set[g];
                end
            end
        end
    endgenerate

    // Category events outside the channel flags; write one to clear
    always @* begin
        sticky_next = sticky_reg;
        if (wr_summary) begin
            sticky_next = sticky_next & ~wb_dat_i[7:0];
        end
        if (wr_reset_flags) begin
            sticky_next = 8'h00;
        end
        // Set wins over any clear in the same cycle
        sticky_next[`PEFIM_BIT_SUPPLY] = sticky_next[`PEFIM_BIT_SUPPLY] | supply_fault_i;
        sticky_next[`PEFIM_BIT_START] = sticky_next[`PEFIM_BIT_START] | start_fault_i;
        sticky_next[`PEFIM_BIT_OVERCUR] = sticky_next[`PEFIM_BIT_OVERCUR] | overcurrent_i;
        sticky_next[`PEFIM_BIT_DISCON] = sticky_next[`PEFIM_BIT_DISCON] | disconnect_i;
        // Channel categories live in the flag registers, not here
        sticky_next[`PEFIM_BIT_CLASS] = 1'b0;
        sticky_next[`PEFIM_BIT_DETECT] = 1'b0;
        sticky_next[`PEFIM_BIT_PGOOD] = 1'b0;
        sticky_next[`PEFIM_BIT_PENABLE] = 1'b0;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            sticky_reg <= `PEFIM_STICKY_RESET;
        end else begin
            sticky_reg <= sticky_next;
        end
    end

    // Strap pins come from outside, so two flops before use
    // Sync flops clear in reset, so the strap reads as off until filled
    always @(posedge clk_i) begin
        if (rst_i) begin
            auto_mode_sync_reg <= 2'b00;
            auto_valid_sync_reg <= 2'b00;
        end else begin
            auto_mode_sync_reg <= {auto_mode_sync_reg[0], auto_mode_i};
            auto_valid_sync_reg <= {auto_valid_sync_reg[0], auto_resistor_valid_i};
        end
    end

    // Mask: the strap is caught a few edges after reset release,
    // once the synchroniser has filled; it acts once per reset and a
    // strap that moves later is ignored
    always @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= `PEFIM_MASK_RESET;
            strap_pending_reg <= 1'b1;
            strap_wait_reg <= 2'b00;
        end else if (strap_pending_reg) begin
            strap_wait_reg <= strap_wait_reg + 2'b01;
            if (strap_wait_reg == `PEFIM_STRAP_WAIT) begin
                strap_pending_reg <= 1'b0;
                if (auto_mode_sync_reg[1] && auto_valid_sync_reg[1]) begin
                    mask_reg <= `PEFIM_MASK_AUTO;
                end
            end
        end else if (wr_mask) begin
            mask_reg <= wb_dat_i[7:0];
        end
    end

    // General mask: global allow and change-only selects
    // A select change acts on the next event pulse; set flags stay
    always @(posedge clk_i) begin
        if (rst_i) begin
            gen_reg <= `PEFIM_GEN_RESET;
        end else if (wr_gen) begin
            gen_reg <= wb_dat_i[7:0];
        end
    end

    // Read mux; both flag indices return the same image
    // Reading never clears here; clear-on-read acts in the flag processes
    always @* begin
        rdata_next = 8'h00;
        if (hit(wb_adr_i, `PEFIM_IDX_SUMMARY)) begin
            rdata_next = summary;
        end else if (hit(wb_adr_i, `PEFIM_IDX_MASK)) begin
            rdata_next = mask_reg;
        end else if (hit(wb_adr_i, `PEFIM_IDX_PWR) || hit(wb_adr_i, `PEFIM_IDX_PWR_CLR)) begin
            rdata_next = power_flags;
        end else if (hit(wb_adr_i, `PEFIM_IDX_DISC) || hit(wb_adr_i, `PEFIM_IDX_DISC_CLR)) begin
            rdata_next = discovery_flags;
        end else if (hit(wb_adr_i, `PEFIM_IDX_GEN_MASK)) begin
            rdata_next = gen_reg;
        end
    end

    // Ack one cycle after the request; unmapped reads give zero
    // Read data is caught at the taking edge so it stands with ack
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ack_reg <= access;
            if (access && !wb_we_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Interrupt pin, registered so it deasserts a cycle after the clear;
    // the extra cycle of latency buys a pin free of decode glitches
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= ~irq_want;
        end
    end

    // Upper lanes tied to zero; only the low byte is mapped
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = {24'h000000, rdata_reg};
    assign irq_n_o = irq_n_reg;

endmodule // pefim_event_irq

`default_nettype wire

// file: verif/pefim_event_irq_monitor.sv
// Purpose: Timing checks on bus answers and interrupt edges
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the design from the bench top file
`timescale 1ns/10ps
`default_nettype none
module pefim_event_irq_monitor #(parameter CHANNELS = 4) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [CHANNELS-1:0] penable_change_i,
    input wire logic [CHANNELS-1:0] pgood_change_i,
    input wire logic [CHANNELS-1:0] class_done_i,
    input wire logic [CHANNELS-1:0] class_changed_i,
    input wire logic [CHANNELS-1:0] detect_done_i,
    input wire logic [CHANNELS-1:0] detect_changed_i,
    input wire logic [CHANNELS-1:0] channel_off_i,
    input wire logic supply_fault_i,
    input wire logic start_fault_i,
    input wire logic overcurrent_i,
    input wire logic disconnect_i,
    input wire logic irq_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Any pulse that may set a flag, any turn-off that may clear one
    wire logic ev_any = |{penable_change_i, pgood_change_i, class_done_i, class_changed_i,
        detect_done_i, detect_changed_i, supply_fault_i, start_fault_i, overcurrent_i,
        disconnect_i};
    wire logic off_any = |channel_off_i;
    // Request and its one-cycle answer
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> s_ack_pulse)
        else $error("ack not one cycle after request");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
        else $error("ack without request");
    AST_NO_SPUR: assert property (!wb_stb_i |=> !wb_ack_o)
        else $error("ack while idle");
    AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    // Read data only moves with a read answer
    AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data moved without read");
    // Release needs a bus access or a turn-off two edges back
    AST_IRQ_RELEASE: assert property ($rose(irq_n_o) |-> $past(wb_ack_o) || $past(off_any, 2))
        else $error("irq released without cause");
    AST_IRQ_ASSERT: assert property ($fell(irq_n_o) |->
        $past(ev_any, 2) || $past(wb_ack_o) || $past(rst_i, 2))
        else $error("irq asserted without cause");
endmodule // pefim_event_irq_monitor
`default_nettype wire

// file: verif/pefim_host_model.sv
// Purpose: Host processor issuing classic Wishbone single cycles
// Assumes: Slave answers with ack on some later edge
// Notes:   Released address and data show inverted values
`timescale 1ns/10ps
`default_nettype none
module pefim_host_model (
    input wire logic clk_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    // Idle bus at time zero
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = 47'h0;
    end
    // Held until ack is seen at an edge; only the bench watchdog ends a dead wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, w};
        wb_adr_o <= a;
        wb_sel_o <= 4'hF;
        wb_dat_o <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_i !== 1'b1) @(posedge clk_i);
        q = wb_dat_i;
        {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
        wb_adr_o <= ~a;
        wb_dat_o <= ~{24'h0, d};
        @(posedge clk_i);
    endtask
endmodule // pefim_host_model
`default_nettype wire

// file: verif/pefim_event_irq_tb.sv
// Purpose: Self-checking bench for the event flag and interrupt block
// Assumes: Host model owns the Wishbone port
// Notes:   Events come from one packed pulse vector
`timescale 1ns/10ps
`default_nettype none
module pefim_event_irq_tb;
    logic clk_i, rst_i, auto_i;
    logic [1:0] four_pair, single_sig;
    logic [31:0] ev;
    int err_count, checked;
    wire logic cyc, stb, we, ack, irq_n;
    wire logic [7:0] adr;
    wire logic [3:0] sel;
    wire logic [31:0] wdat, rdat;
    pefim_host_model i_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
    pefim_event_irq #(.CHANNELS(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .penable_change_i(ev[3:0]), .pgood_change_i(ev[7:4]),
        .class_done_i(ev[11:8]), .class_changed_i(ev[15:12]), .detect_done_i(ev[19:16]),
        .detect_changed_i(ev[23:20]), .channel_off_i(ev[27:24]), .four_pair_i(four_pair),
        .single_signature_i(single_sig), .supply_fault_i(ev[31]), .start_fault_i(ev[30]),
        .overcurrent_i(ev[29]), .disconnect_i(ev[28]), .auto_mode_i(auto_i),
        .auto_resistor_valid_i(auto_i), .irq_n_o(irq_n));
    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 8'h00, q);
        chk_reg(q, {24'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask
    // Pulse one cycle, then let flag and irq registers settle
    task automatic pulse(input logic [31:0] v);
        ev <= v;
        @(posedge clk_i);
        ev <= 32'h0;
        repeat (2) @(posedge clk_i);
    endtask
    // Six idle edges cover the strap window before bus use
    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic t_reset;
        rdc(8'h04, 8'h80);
        rdc(8'h08, 8'h00);
        rdc(8'h00, 8'h80);
        chk_irq(irq_n, 1'b0);
        rdc(8'hFC, 8'h00);
    endtask
    task automatic t_mask;
        wr(8'h00, 8'h80);
        chk_irq(irq_n, 1'b1);
        wr(8'h04, 8'h01);
        pulse(32'h4);
        chk_irq(irq_n, 1'b0);
        wr(8'h04, 8'h00);
        chk_irq(irq_n, 1'b1);
        rdc(8'h00, 8'h01);
        wr(8'h04, 8'h01);
        wr(8'h40, 8'h00);
        chk_irq(irq_n, 1'b1);
        wr(8'h40, 8'h80);
        chk_irq(irq_n, 1'b0);
    endtask
    task automatic t_power;
        four_pair <= 2'b01;
        pulse(32'h21);
        rdc(8'h08, 8'h25);
        rdc(8'h0C, 8'h25);
        chk_irq(irq_n, 1'b1);
        rdc(8'h08, 8'h00);
        four_pair <= 2'b11;
        single_sig <= 2'b01;
        pulse(32'h10);
        rdc(8'h08, 8'h00);
        pulse(32'h20);
        rdc(8'h08, 8'h30);
        pulse(32'h40);
        rdc(8'h0C, 8'h70);
    endtask
    task automatic t_disc;
        pulse(32'h0008_0100);
        wr(8'h40, 8'h83);
        pulse(32'h0002_0200);
        rdc(8'h10, 8'h18);
        pulse(32'h0011_2200);
        rdc(8'h10, 8'h39);
        rdc(8'h00, 8'h18);
        pulse(32'h0800_0000);
        rdc(8'h10, 8'h31);
        rdc(8'h14, 8'h31);
        rdc(8'h10, 8'h00);
        wr(8'h04, 8'h04);
        pulse(32'h7000_0000);
        rdc(8'h00, 8'h64);
        chk_irq(irq_n, 1'b0);
        wr(8'h00, 8'h64);
        chk_irq(irq_n, 1'b1);
    endtask
    // Flag reset register wipes every flag and the summary
    task automatic t_flag_reset;
        pulse(32'h8010_0001);
        rdc(8'h00, 8'h89);
        wr(8'h68, 8'h80);
        rdc(8'h00, 8'h00);
        rdc(8'h08, 8'h00);
        rdc(8'h10, 8'h00);
    endtask
    // Strap power-up last since it resets everything
    task automatic t_strap;
        auto_i <= 1'b1;
        do_reset();
        rdc(8'h04, 8'hE4);
        chk_irq(irq_n, 1'b0);
    endtask
    task automatic summarize;
        $display("Checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence; strap power-up last since it resets everything
    initial begin
        {rst_i, auto_i, four_pair, single_sig, ev, err_count, checked} = {1'b1, 37'h0, 64'h0};
        do_reset();
        t_reset();
        t_mask();
        t_power();
        t_disc();
        t_flag_reset();
        t_strap();
        summarize();
    end
    // Watchdog far beyond the roughly 150 cycles needed
    initial begin
        repeat (3000) @(posedge clk_i);
        err_count++;
        summarize();
    end
endmodule // pefim_event_irq_tb
bind pefim_event_irq pefim_event_irq_monitor #(.CHANNELS(CHANNELS)) i_mon (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .penable_change_i, .pgood_change_i,
    .class_done_i, .class_changed_i, .detect_done_i, .detect_changed_i, .channel_off_i,
    .supply_fault_i, .start_fault_i, .overcurrent_i, .disconnect_i, .irq_n_o);
`default_nettype wire
